// file: dma_chain_channel.sv
// linked-descriptor channel sequencer with flag register, on apb
//
// Summary of operation
// R01: transaction is one or chained blocks
// R02: after block, fetch descriptor at next pointer
// R03: null next pointer ends the transaction
// R04: fetch error sets suspend and fetch-error
// R05: software appends with null next pointer
// R06: software enables suspend interrupt, then channel
// R07: software clears valid, reads write-back pointer
// R08: unfetched target edited in place, resume optional
// R09: running target: suspend, patch write-back, resume
// R10: suspend set by action, command, event, invalid
// R11: write one clears suspend flag bit 2
// R12: flag access uses channel select
// R13: done flag set on block with interrupt
// R14: error flag set on bus or invalid
// R15: interrupt while enabled flag set
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module dma_chain_channel (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   // descriptor fetch on the system bus
   output dma_chain_pkg::mem_req_t     memReq,
   input  wire dma_chain_pkg::mem_rsp_t memRsp,
   // block engine and events, one bit per channel
   output logic      [3:0]             blockStart,
   input  wire logic [3:0]             blockDone,
   input  wire logic [3:0]             beatError,
   input  wire logic [3:0]             suspendEvent,
   // interrupt
   output logic                        irq
);
   import dma_chain_pkg::*;

   logic        rstMeta_q, rstSync_q;
   logic [1:0]  chanSel_q;
   logic [2:0]  flags_q [CHANNELS];
   logic [2:0]  mask_q [CHANNELS];
   logic        enable_q [CHANNELS];
   logic        fetchErr_q [CHANNELS];
   logic [31:0] firstDesc_q [CHANNELS];
   chan_state_t state_q [CHANNELS];
   logic [1:0]  action_q [CHANNELS];
   logic [1:0]  fetchWord_q;
   logic        busOwned_q;
   logic [1:0]  owner_q;
   logic [31:0] descBase_q;
   logic [31:0] nextPtr_q [CHANNELS];
   logic        autoGo_q [CHANNELS];
   logic [31:0] wbRd;
   logic        wbWr;
   logic [1:0]  wbWrIdx;
   logic [31:0] wbWrData;
   logic        apbWr, apbRd;
   logic [3:0]  setSusp, setDone, setErr;
   logic [3:0]  swSuspend, swResume, swStart;
   block_ctrl_t ctrlSeen;

   ////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb decode: zero wait state, write in access phase
   assign apbWr = psel && penable && pwrite;
   assign apbRd = psel && !penable && !pwrite;

   always_comb begin
      for (int c = 0; c < CHANNELS; c++) begin
         swSuspend[c] = apbWr && paddr == CHANNEL_CTRL_ADR &&
                        chanSel_q == 2'(c) && pwdata[CTRL_SUSPEND];
         swResume[c] = apbWr && paddr == CHANNEL_CTRL_ADR &&
                       chanSel_q == 2'(c) && pwdata[CTRL_RESUME];
         swStart[c] = apbWr && paddr == CHANNEL_CTRL_ADR &&
                      chanSel_q == 2'(c) && pwdata[CTRL_ENABLE];
      end
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         chanSel_q <= 2'h0;
         for (int c = 0; c < CHANNELS; c++) begin
            mask_q[c] <= 3'h0;
            enable_q[c] <= 1'b0;
            firstDesc_q[c] <= 32'h0;
         end
      end else if (apbWr) begin
         case (paddr)
            CHANNEL_SELECT_ADR: chanSel_q <= pwdata[1:0];
            CHANNEL_CTRL_ADR: enable_q[chanSel_q] <= pwdata[CTRL_ENABLE];
            FIRST_DESC_ADR: firstDesc_q[chanSel_q] <= pwdata;
            IRQ_MASK_ADR: mask_q[chanSel_q] <= pwdata[2:0];
            default: ;
         endcase
      end
   end

   // read data registered in setup so it is valid in access phase
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(paddr == CHANNEL_SELECT_ADR ||
                    paddr == CHANNEL_CTRL_ADR ||
                    paddr == CHANNEL_STATE_ADR ||
                    paddr == FIRST_DESC_ADR ||
                    paddr == WRITEBACK_NEXT_ADR ||
                    paddr == IRQ_MASK_ADR || paddr == CHANNEL_FLAGS_ADR);
         if (apbRd) begin
            case (paddr)
               CHANNEL_SELECT_ADR: prdata <= {30'h0, chanSel_q};
               CHANNEL_CTRL_ADR: prdata <= {31'h0, enable_q[chanSel_q]};
               CHANNEL_STATE_ADR: prdata <= {29'h0,
                  fetchErr_q[chanSel_q],
                  state_q[chanSel_q] == ST_SUSPEND,
                  state_q[chanSel_q] != ST_IDLE};
               FIRST_DESC_ADR: prdata <= firstDesc_q[chanSel_q];
               WRITEBACK_NEXT_ADR: prdata <= wbRd;
               IRQ_MASK_ADR: prdata <= {29'h0, mask_q[chanSel_q]};
               CHANNEL_FLAGS_ADR: prdata <= {29'h0, flags_q[chanSel_q]};
               default: prdata <= 32'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // write-back memory: patched by software, refreshed on each fetch
   assign wbWr = (apbWr && paddr == WRITEBACK_NEXT_ADR) ||
                 (busOwned_q && memRsp.valid && fetchWord_q == 2'h1);
   assign wbWrIdx = busOwned_q && memRsp.valid ? owner_q : chanSel_q;
   assign wbWrData = busOwned_q && memRsp.valid ? memRsp.data : pwdata;

   writeback_ram wbMem (
      .clk    (clk),
      .wrEn   (wbWr),
      .wrIdx  (wbWrIdx),
      .wrData (wbWrData),
      .rdIdx  (chanSel_q),
      .rdData (wbRd)
   );

   ////////////////////////////////////////////////////////////////////
   // per-channel sequencer; one fetch master shared in turn
   assign ctrlSeen = decode_ctrl(memRsp.data);

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         busOwned_q <= 1'b0;
         owner_q <= 2'h0;
         fetchWord_q <= 2'h0;
         descBase_q <= 32'h0;
         memReq <= '0;
         blockStart <= 4'h0;
         setSusp <= 4'h0;
         setDone <= 4'h0;
         setErr <= 4'h0;
         for (int c = 0; c < CHANNELS; c++) begin
            state_q[c] <= ST_IDLE;
            action_q[c] <= ACT_NONE;
            fetchErr_q[c] <= 1'b0;
            nextPtr_q[c] <= 32'h0;
            autoGo_q[c] <= 1'b0;
         end
      end else begin
         blockStart <= 4'h0;
         setSusp <= suspendEvent | swSuspend;                  // [R10]
         setDone <= 4'h0;
         setErr <= beatError;                                  // [R14]
         if (apbWr && paddr == WRITEBACK_NEXT_ADR)
            nextPtr_q[chanSel_q] <= pwdata;                    // [R09]
         for (int c = 0; c < CHANNELS; c++) begin
            case (state_q[c])
               ST_IDLE: begin
                  if (swStart[c] && !busOwned_q &&
                      firstDesc_q[c] != NULL_POINTER) begin    // [R01]
                     busOwned_q <= 1'b1;
                     owner_q <= 2'(c);
                     descBase_q <= firstDesc_q[c];
                     fetchWord_q <= 2'h0;
                     memReq <= '{req: 1'b1, addr: firstDesc_q[c]};
                     fetchErr_q[c] <= 1'b0;
                     state_q[c] <= ST_FETCH;
                  end
               end
               ST_FETCH: begin
                  if (memRsp.valid && memRsp.err) begin
                     memReq <= '0;
                     busOwned_q <= 1'b0;
                     fetchErr_q[c] <= 1'b1;                    // [R04]
                     setSusp[c] <= 1'b1;                       // [R04]
                     state_q[c] <= ST_SUSPEND;
                  end else if (memRsp.valid && fetchWord_q == 2'h0) begin
                     if (!ctrlSeen.valid) begin
                        memReq <= '0;
                        busOwned_q <= 1'b0;
                        setSusp[c] <= 1'b1;                    // [R10]
                        setErr[c] <= 1'b1;                     // [R14]
                        state_q[c] <= ST_SUSPEND;
                     end else begin
                        action_q[c] <= ctrlSeen.action;
                        fetchWord_q <= 2'h1;
                        memReq.addr <= descBase_q + DESC_NEXT_OFS;
                     end
                  end else if (memRsp.valid) begin
                     memReq <= '0;
                     busOwned_q <= 1'b0;
                     nextPtr_q[c] <= memRsp.data;
                     state_q[c] <= ST_DECODE;
                  end
               end
               ST_DECODE: begin
                  blockStart[c] <= 1'b1;
                  state_q[c] <= ST_BLOCK;
               end
               ST_BLOCK: begin
                  if (swSuspend[c] || suspendEvent[c]) begin
                     state_q[c] <= ST_SUSPEND;
                  end else if (blockDone[c]) begin
                     setDone[c] <= action_q[c][0];              // [R13]
                     setSusp[c] <= action_q[c][1];              // [R10]
                     autoGo_q[c] <= !action_q[c][1] &&
                                    nextPtr_q[c] != NULL_POINTER; // [R02]
                     if (action_q[c][1]) begin
                        state_q[c] <= ST_SUSPEND;
                     end else if (nextPtr_q[c] == NULL_POINTER) begin
                        state_q[c] <= ST_IDLE;                 // [R03]
                     end else begin
                        state_q[c] <= ST_SUSPEND;
                     end
                  end
               end
               ST_SUSPEND: begin
                  // resume or chained block goes on from the write-back
                  // pointer, so a patch made while waiting takes effect
                  if ((swResume[c] || autoGo_q[c]) && !busOwned_q &&
                      !fetchErr_q[c]) begin
                     autoGo_q[c] <= 1'b0;
                     if (nextPtr_q[c] == NULL_POINTER) begin
                        state_q[c] <= ST_IDLE;                 // [R03]
                     end else begin
                        busOwned_q <= 1'b1;
                        owner_q <= 2'(c);
                        descBase_q <= nextPtr_q[c];            // [R02]
                        fetchWord_q <= 2'h0;
                        memReq <= '{req: 1'b1, addr: nextPtr_q[c]};
                        state_q[c] <= ST_FETCH;
                     end
                  end else if (!enable_q[c]) begin
                     state_q[c] <= ST_IDLE;
                  end
               end
               default: state_q[c] <= ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flags: set wins over a same-cycle write-one clear
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         for (int c = 0; c < CHANNELS; c++) begin
            flags_q[c] <= FLAGS_RESET[2:0];                    // [R12]
         end
      end else begin
         for (int c = 0; c < CHANNELS; c++) begin
            logic [2:0] clr;
            clr = (apbWr && paddr == CHANNEL_FLAGS_ADR &&
                   chanSel_q == 2'(c)) ? pwdata[2:0] : 3'h0;   // [R12]
            flags_q[c][FLAG_SUSPEND_FLAG] <= setSusp[c] ||
               (flags_q[c][FLAG_SUSPEND_FLAG] && !clr[FLAG_SUSPEND_FLAG]);     // [R11]
            flags_q[c][FLAG_DONE] <= setDone[c] ||
               (flags_q[c][FLAG_DONE] && !clr[FLAG_DONE]);     // [R13]
            flags_q[c][FLAG_ERR] <= setErr[c] ||
               (flags_q[c][FLAG_ERR] && !clr[FLAG_ERR]);       // [R14]
         end
      end
   end

   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags_q[0] & mask_q[0]) | |(flags_q[1] & mask_q[1]) |
                |(flags_q[2] & mask_q[2]) | |(flags_q[3] & mask_q[3]); // [R15]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   sequence fetch_fail_s;
      busOwned_q && memRsp.valid && memRsp.err;
   endsequence

   fetch_err_suspend_flag_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      fetch_fail_s |-> ##2 flags_q[owner_q][FLAG_SUSPEND_FLAG]) // [R04]
      else $error("fetch error did not set suspend");
   flag_irq_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      |(flags_q[0] & mask_q[0]) |=> irq) // [R15]
      else $error("irq missing for enabled flag");
   suspend_flag_event_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      suspendEvent[0] |-> ##2 flags_q[0][FLAG_SUSPEND_FLAG]) // [R10]
      else $error("suspend event lost");
   beat_err_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      beatError[0] |-> ##2 flags_q[0][FLAG_ERR]) // [R14]
      else $error("bus error flag not set");
   clear_keep_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      (apbWr && paddr == CHANNEL_FLAGS_ADR && chanSel_q == 2'h0 &&
       !pwdata[FLAG_SUSPEND_FLAG] && flags_q[0][FLAG_SUSPEND_FLAG]) |=>
      flags_q[0][FLAG_SUSPEND_FLAG]) // [R11]
      else $error("write zero changed suspend flag");
   clear_one_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      (apbWr && paddr == CHANNEL_FLAGS_ADR && chanSel_q == 2'h0 &&
       pwdata[FLAG_DONE] && !setDone[0]) |=> !flags_q[0][FLAG_DONE]) // [R13]
      else $error("write one did not clear done flag");
   block_start_a: assert property (@(posedge clk) disable iff (!rstSync_q) // [R02]
      (state_q[0] == ST_DECODE) |=> blockStart[0] && state_q[0] == ST_BLOCK)
      else $error("block not started after fetch");
   null_end_a: assert property (@(posedge clk) disable iff (!rstSync_q)
      (state_q[0] == ST_SUSPEND && swResume[0] && !busOwned_q &&
       !fetchErr_q[0] && nextPtr_q[0] == NULL_POINTER) |=>
      state_q[0] == ST_IDLE && !memReq.req) // [R03]
      else $error("null pointer did not end chain");

endmodule

// file: dma_chain_pkg.sv
// package: register map, field layout and types of the descriptor channel
package dma_chain_pkg;

   // register byte addresses (0x4e is not a multiple of four: index * 4)
   localparam logic [7:0]  CHANNEL_FLAGS_IDX = 8'h4e;
   localparam logic [11:0] CHANNEL_FLAGS_ADR = 12'h138;
   localparam logic [11:0] CHANNEL_SELECT_ADR = 12'h000;
   localparam logic [11:0] CHANNEL_CTRL_ADR = 12'h004;
   localparam logic [11:0] CHANNEL_STATE_ADR = 12'h008;
   localparam logic [11:0] FIRST_DESC_ADR = 12'h00c;
   localparam logic [11:0] WRITEBACK_NEXT_ADR = 12'h010;
   localparam logic [11:0] IRQ_MASK_ADR = 12'h014;

   // flag bit positions
   localparam int FLAG_ERR = 0;
   localparam int FLAG_DONE = 1;
   localparam int FLAG_SUSPEND_FLAG = 2;

   // channel control bit positions
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_SUSPEND = 1;
   localparam int CTRL_RESUME = 2;

   // channel state bit positions
   localparam int STATE_BUSY = 0;
   localparam int STATE_SUSPENDED = 1;
   localparam int STATE_FETCH_ERR = 2;

   // block control word fields
   localparam int BLK_VALID = 0;
   localparam int BLK_ACT_LO = 3;
   localparam int BLK_LEN_LO = 16;

   // block actions
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_INT = 2'h1;
   localparam logic [1:0] ACT_SUSPEND = 2'h2;
   localparam logic [1:0] ACT_BOTH = 2'h3;

   localparam int CHANNELS = 4;
   localparam int WB_DEPTH = 4;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [31:0] NULL_POINTER = 32'h0000_0000;

   // descriptor word offsets
   localparam logic [31:0] DESC_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_000c;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_FETCH   = 3'b001,
      ST_DECODE  = 3'b010,
      ST_BLOCK   = 3'b011,
      ST_SUSPEND = 3'b100
   } chan_state_t;

   typedef struct packed {
      logic [15:0] length;
      logic [1:0]  action;
      logic        valid;
   } block_ctrl_t;

   // system bus read port used for descriptor fetch
   typedef struct packed {
      logic        req;
      logic [31:0] addr;
   } mem_req_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [31:0] data;
   } mem_rsp_t;

   function automatic block_ctrl_t decode_ctrl(input logic [31:0] w);
      block_ctrl_t c;
      c.valid = w[BLK_VALID];
      c.action = w[BLK_ACT_LO +: 2];
      c.length = w[BLK_LEN_LO +: 16];
      return c;
   endfunction

endpackage

// file: dma_linked_descriptor_channel_test.sv
// testbench: chained descriptors, flags, suspend and errors over apb
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   failures++; $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
   end end
module dma_linked_descriptor_channel_test;
   import dma_chain_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   mem_req_t    memReq;
   mem_rsp_t    memRsp;
   logic [3:0]  blockStart;
   logic [3:0]  blockDone;
   logic [3:0]  beatError = 4'h0;
   logic [3:0]  suspendEvent = 4'h0;
   logic        irq;
   logic [31:0] rd;
   logic        er;
   int          failures = 0;
   int          num_checks = 0;
   int          fetchCnt = 0;
   int          startCnt = 0;
   int          n0 = 0;
   logic [31:0] lastAdr = 32'h0;

   always #2.5 clk = ~clk;

   dma_chain_channel u_dut (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
      .memRsp(memRsp), .blockStart(blockStart), .blockDone(blockDone),
      .beatError(beatError), .suspendEvent(suspendEvent), .irq(irq));
   sys_bus_model #(.BLOCK_LAT(40)) u_mem (.clk(clk), .memReq(memReq),
      .memRsp(memRsp),
      .blockStart(blockStart), .blockDone(blockDone));

   always @(posedge clk) begin
      if (memRsp.valid) begin
         fetchCnt++;
         lastAdr = memReq.addr;
      end
      if (blockStart[0] === 1'b1) startCnt++;
   end

   ///////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // one apb transfer; idle cycle in front keeps drivers off shared steps
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         failures++;
         final_report();
      end
   endtask

   // poll a register until the masked value matches
   task automatic poll(input logic [11:0] a, input logic [31:0] m,
                       input logic [31:0] want);
      int n;
      n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while ((rd & m) !== want && n < 100);
      if (n >= 100) begin
         failures++;
         final_report();
      end
   endtask

   task automatic put_desc(input logic [31:0] a, input logic [1:0] act,
                           input logic v, input logic [31:0] nx);
      u_mem.mem[a[11:2]] = {16'h0010, 11'h000, act, 2'b00, v};
      u_mem.mem[a[11:2] + 3] = nx;
   endtask

   task automatic pulse(input logic isErr);
      @(posedge clk);
      if (isErr) beatError <= 4'h1;
      else suspendEvent <= 4'h1;
      @(posedge clk);
      beatError <= 4'h0;
      suspendEvent <= 4'h0;
   endtask

   ///////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd, {24'h0, FLAGS_RESET})
      apb(1'b0, 12'h0fc, 32'h0);
      `CHK(er, 1'b1)
      // two linked blocks, the second ends the chain
      put_desc(32'h100, ACT_INT, 1'b1, 32'h200);
      put_desc(32'h200, ACT_INT, 1'b1, NULL_POINTER);
      apb(1'b1, IRQ_MASK_ADR, 32'h7);
      apb(1'b1, CHANNEL_SELECT_ADR, 32'h0);
      apb(1'b1, FIRST_DESC_ADR, 32'h100);
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h1);
      poll(CHANNEL_FLAGS_ADR, 32'h2, 32'h2);
      poll(CHANNEL_STATE_ADR, 32'h1, 32'h0);
      repeat (20) @(posedge clk);
      `CHK(startCnt, 2)
      `CHK(lastAdr, 32'h20c)
      `CHK(fetchCnt, 4)
      `CHK(irq, 1'b1)
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h0);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd, 32'h2)
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h2);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd, 32'h0)
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      // suspend block action with interrupts masked
      apb(1'b1, IRQ_MASK_ADR, 32'h0);
      put_desc(32'h300, ACT_SUSPEND, 1'b1, NULL_POINTER);
      apb(1'b1, FIRST_DESC_ADR, 32'h300);
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h1);
      poll(CHANNEL_FLAGS_ADR, 32'h4, 32'h4);
      `CHK(rd, 32'h4)
      repeat (3) @(posedge clk);
      `CHK(irq, 1'b0)
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h4);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h5);
      poll(CHANNEL_STATE_ADR, 32'h1, 32'h0);
      repeat (20) @(posedge clk);
      `CHK(fetchCnt, 6)
      // suspend event and bus error
      pulse(1'b0);
      pulse(1'b1);
      repeat (4) @(posedge clk);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd, 32'h5)
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h5);
      // invalid descriptor
      put_desc(32'h400, ACT_NONE, 1'b0, NULL_POINTER);
      apb(1'b1, FIRST_DESC_ADR, 32'h400);
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h1);
      poll(CHANNEL_FLAGS_ADR, 32'h5, 32'h5);
      `CHK(rd, 32'h5)
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h5);
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h0);
      // descriptor fetch answered with a bus error
      u_mem.errAdr = 32'h500;
      apb(1'b1, IRQ_MASK_ADR, 32'h4);
      apb(1'b1, FIRST_DESC_ADR, 32'h500);
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h1);
      poll(CHANNEL_FLAGS_ADR, 32'h4, 32'h4);
      apb(1'b0, CHANNEL_STATE_ADR, 32'h0);
      `CHK(rd[STATE_FETCH_ERR], 1'b1)
      `CHK(irq, 1'b1)
      // flags follow the selected channel
      apb(1'b1, CHANNEL_SELECT_ADR, 32'h1);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b1, CHANNEL_SELECT_ADR, 32'h0);
      apb(1'b0, CHANNEL_FLAGS_ADR, 32'h0);
      `CHK(rd[FLAG_SUSPEND_FLAG], 1'b1)
      // suspend a running block, patch the write-back pointer, resume
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h0);
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h7);
      put_desc(32'h600, ACT_NONE, 1'b1, 32'h700);
      put_desc(32'h700, ACT_INT, 1'b1, NULL_POINTER);
      apb(1'b1, FIRST_DESC_ADR, 32'h600);
      n0 = startCnt;
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h1);
      for (int i = 0; i < 100 && startCnt == n0; i++) @(posedge clk);
      `CHK(startCnt, n0 + 1)
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h3);
      poll(CHANNEL_FLAGS_ADR, 32'h4, 32'h4);
      `CHK(irq, 1'b1)
      apb(1'b0, WRITEBACK_NEXT_ADR, 32'h0);
      `CHK(rd, 32'h700)
      put_desc(32'h800, ACT_INT, 1'b1, NULL_POINTER);
      apb(1'b1, WRITEBACK_NEXT_ADR, 32'h800);
      apb(1'b1, CHANNEL_FLAGS_ADR, 32'h7);
      apb(1'b1, CHANNEL_CTRL_ADR, 32'h5);
      poll(CHANNEL_FLAGS_ADR, 32'h2, 32'h2);
      poll(CHANNEL_STATE_ADR, 32'h1, 32'h0);
      `CHK(lastAdr, 32'h80c)
      final_report();
   end
endmodule

// file: sys_bus_model.sv
// partner model: system bus sram for descriptor fetch, block engine stub
`timescale 1ns/1ps
module sys_bus_model #(
   parameter int MEM_LAT   = 3,
   parameter int BLOCK_LAT = 6
) (
   // clock
   input  wire logic                    clk,
   // descriptor fetch
   input  wire dma_chain_pkg::mem_req_t memReq,
   output dma_chain_pkg::mem_rsp_t      memRsp,
   // block engine
   input  wire logic [3:0]              blockStart,
   output logic      [3:0]              blockDone
);
   import dma_chain_pkg::*;
   logic [31:0] mem [0:1023];
   logic [31:0] errAdr = 32'hffff_fffc;
   int          waitCnt = 0;
   int          blkCnt [4] = '{default: 0};

   initial begin
      memRsp = '0;
      blockDone = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////
   // one response per held request; data flips when no answer stands
   always @(posedge clk) begin
      memRsp.valid <= 1'b0;
      memRsp.err <= 1'b0;
      memRsp.data <= ~memRsp.data;
      if (memReq.req && !memRsp.valid) begin
         if (waitCnt == MEM_LAT) begin
            waitCnt <= 0;
            memRsp.valid <= 1'b1;
            memRsp.err <= (memReq.addr == errAdr);
            memRsp.data <= mem[memReq.addr[11:2]];
         end else begin
            waitCnt <= waitCnt + 1;
         end
      end else begin
         waitCnt <= 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a started block finishes a fixed time later
   always @(posedge clk) begin
      for (int i = 0; i < 4; i++) begin
         blockDone[i] <= (blkCnt[i] == 1);
         if (blockStart[i]) begin
            blkCnt[i] <= BLOCK_LAT;
         end else if (blkCnt[i] > 0) begin
            blkCnt[i] <= blkCnt[i] - 1;
         end
      end
   end
endmodule

// file: writeback_ram.sv
// small write-back memory: one next pointer per channel, registered read
`timescale 1ns/1ps
module writeback_ram (
   // clock
   input  wire logic        clk,
   // write port
   input  wire logic        wrEn,
   input  wire logic [1:0]  wrIdx,
   input  wire logic [31:0] wrData,
   // read port
   input  wire logic [1:0]  rdIdx,
   output logic      [31:0] rdData
);
   import dma_chain_pkg::*;

   logic [31:0] mem [WB_DEPTH];

   always_ff @(posedge clk) begin
      if (wrEn) begin
         mem[wrIdx] <= wrData;
      end
      rdData <= mem[rdIdx];
   end

endmodule
